// [dv/ccl_bank_properties.sv]
// port checks on the assessment bank
`timescale 1ns/1ps
module ccl_bank_chk #(parameter int ASSESS_CYCLES = 20) (
   // clock, reset, registers
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire ccl_pkg::ccl_reg_req_t i_reg_req,
   input wire logic i_reg_valid,
   input wire logic [7:0] o_reg_rdata,
   // frames and events
   input wire ccl_pkg::ccl_byte_t i_rx_byte,
   input wire logic i_frame_last,
   input wire logic o_assess_done_event,
   input wire ccl_pkg::ccl_byte_t o_buf_byte,
   input wire logic o_frame_end_event
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);
   // the registered done pulse is sampled one edge after the window ends
   localparam int DONE_AT = ASSESS_CYCLES + 1;
   int cnt;
   logic seen;
   wire [5:0] a = i_reg_req.addr;
   wire rd = i_reg_valid && !i_reg_req.we;
   wire start = i_reg_valid && i_reg_req.we && a == 6'h08 && i_reg_req.wdata[7];
   // cycles since the last accepted request
   always_ff @(posedge i_ref_clk) begin
      cnt <= (i_reset || !start && (cnt == 0 || cnt == DONE_AT)) ? 0 : start ? 1 : cnt + 1;
      seen <= !i_reset && !start && (seen || o_assess_done_event);
   end
   a_done_time: assert property (o_assess_done_event |-> cnt == DONE_AT)
      else $error("done early or late");
   a_done_due: assert property (cnt == DONE_AT |-> o_assess_done_event)
      else $error("done missing");
   a_flags_pend: assert property (rd && a == 6'h01 && cnt inside {[1:ASSESS_CYCLES - 2]}
      |=> o_reg_rdata[7:6] == 2'b00)
      else $error("stale flags");
   a_done_hold: assert property (rd && a == 6'h01 && seen |=> o_reg_rdata[7])
      else $error("done flag lost");
   a_req_zero: assert property (rd && a == 6'h08 |=> !o_reg_rdata[7])
      else $error("request bit stuck");
   a_unmapped_zero: assert property (rd && !(a inside {6'h01, 6'h08, 6'h09})
      |=> o_reg_rdata == 8'h00)
      else $error("unmapped data");
   a_quality_end: assert property (i_frame_last |=> o_frame_end_event && o_buf_byte.valid)
      else $error("no quality byte");
   a_byte_pass: assert property (i_rx_byte.valid
      |=> o_buf_byte == {1'b1, $past(i_rx_byte.data)})
      else $error("payload byte wrong");
   c_done: cover property (o_assess_done_event);
   c_restart: cover property (start && cnt != 0);
   c_frame: cover property (o_frame_end_event);
endmodule // ccl_bank_chk
bind ccl_bank ccl_bank_chk #(.ASSESS_CYCLES(ASSESS_CYCLES)) i_chk (.*);

// [dv/ccl_host.sv]
// host register access model
`timescale 1ns/1ps
module ccl_host (
   // clock and read data
   input wire logic i_ref_clk,
   input wire logic [7:0] i_rdata,
   // register request
   output ccl_pkg::ccl_reg_req_t o_req,
   output logic o_valid = 1'b0
);
   initial o_req = '0;
   task automatic access(input logic we, input logic [5:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge i_ref_clk) #1;
      o_req = '{we, a, d};
      o_valid = 1'b1;
      @(posedge i_ref_clk) #1;
      o_valid = 1'b0;
      q = i_rdata;
   endtask
endmodule // ccl_host

// [dv/testbench.sv]
// self-checking bench for the assessment bank
`timescale 1ns/1ps
module testbench;
   localparam int N = 20;
   logic clk = 1'b0, rst = 1'b1, car = 1'b0, sv = 1'b0, last = 1'b0, act = 1'b0;
   logic signed [7:0] pwr = 8'sh00;
   logic [7:0] rdata, q;
   logic valid, done, fend;
   ccl_pkg::ccl_reg_req_t req;
   ccl_pkg::ccl_byte_t rxb = '0, bufb;
   int n_errors = 0;
   int comparisons = 0;
   // {idle expected, method, threshold, power, carrier}
   logic [16:0] rows [10] = '{17'h00b74, 17'h00b57, 17'h10b56, 17'h04b63, 17'h14b61,
      17'h17f74, 17'h18b74, 17'h08b39, 17'h0cb75, 17'h1cb74};
   ccl_host i_host (.i_ref_clk(clk), .i_rdata(rdata), .o_req(req), .o_valid(valid));
   ccl_bank #(.ASSESS_CYCLES(N)) i_dut (.i_ref_clk(clk), .i_reset(rst), .i_reg_req(req),
      .i_reg_valid(valid), .o_reg_rdata(rdata), .i_trx_state(5'h15), .i_rx_power(pwr),
      .i_floor(8'sha6), .i_carrier_seen(car), .i_rx_active(act), .i_rx_byte(rxb),
      .i_sym_valid(sv), .i_sym_corr(8'h50), .i_frame_last(last),
      .o_assess_done_event(done), .o_buf_byte(bufb), .o_frame_end_event(fend));
   always #50 clk = ~clk;
   task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rg(input logic we, input logic [5:0] a, input logic [7:0] d);
      i_host.access(we, a, d, q);
   endtask
   task automatic assess(input logic [7:0] c);
      int n;
      rg(1'b1, 6'h08, c);
      for (n = 0; n < 99 && done !== 1'b1; n++)
         @(posedge clk) #1;
      chk("done delay", 9'(N), 9'(n));
      rg(1'b0, 6'h01, 8'h00);
   endtask
   task automatic frame(input int len, input logic [7:0] lq);
      @(posedge clk) #1;
      act = 1'b1;
      for (int i = 0; i <= len; i++) begin
         rxb = '{i < len, 8'h30 + 8'(i)};
         sv = i < len;
         last = i == len;
         @(posedge clk) #1;
         chk("buffer byte", {1'b1, i < len ? 8'h30 + 8'(i) : lq}, bufb);
      end
      chk("frame end", 9'h001, {8'h00, fend});
      {rxb, sv, last, act} = '0;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      rg(1'b0, 6'h09, 8'h00);
      chk("threshold reset", 9'h0c7, {1'b0, q});
      rg(1'b0, 6'h3f, 8'h00);
      chk("unmapped read", 9'h000, {1'b0, q});
      rg(1'b1, 6'h01, 8'hff);
      rg(1'b1, 6'h3f, 8'h5a);
      rg(1'b0, 6'h01, 8'h00);
      chk("status", 9'h015, {1'b0, q});
      for (int k = 0; k < 10; k++) begin
         {pwr, car} = rows[k][8:0];
         rg(1'b1, 6'h09, {3'h7, rows[k][13:9]});
         assess({1'b1, rows[k][15:14], 5'h0b});
         chk("status", {2'b01, rows[k][16], 6'h15}, {1'b0, q});
      end
      rg(1'b0, 6'h08, 8'h00);
      chk("control", 9'h06b, {1'b0, q});
      rg(1'b1, 6'h08, 8'h80);
      rg(1'b0, 6'h01, 8'h00);
      chk("pending status", 9'h015, {1'b0, q});
      {pwr, car} = 9'h138;
      assess(8'h80);
      chk("status", 9'h0d5, {1'b0, q});
      frame(3, 8'h50);
      frame(1, 8'h00);
      // reset in the middle of a measurement
      rg(1'b1, 6'h09, 8'h00);
      rg(1'b1, 6'h08, 8'he5);
      rst = 1'b1;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      for (int k = 0; k < N + 2; k++) begin
         @(posedge clk) #1;
         chk("done after reset", 9'h000, {8'h00, done});
      end
      rg(1'b0, 6'h09, 8'h00);
      chk("threshold after reset", 9'h0c7, {1'b0, q});
      rg(1'b0, 6'h08, 8'h00);
      chk("control after reset", 9'h000, {1'b0, q});
      rg(1'b0, 6'h01, 8'h00);
      chk("status after reset", 9'h015, {1'b0, q});
      tally_and_finish();
   end
   initial begin
      #1000000;
      n_errors++;
      tally_and_finish();
   end
endmodule // testbench

// [hw/ccl_bank.sv]
// assessment control/status registers and per-frame quality byte generation
// Operation
// - on completion status bit 6 shows result: 0 busy, 1 idle
// - a new request clears the idle result bit
// - writing 1 to control bit 7 starts assessment; completion raises done event
// - request bit clears itself once accepted and reads back zero
// - method bits 6:5 select OR, energy, carrier, AND decisions
// - energy busy when power exceeds floor plus twice threshold field
// - methods 0 and 3 combine energy and carrier with OR and AND
// - every received frame gets one extra quality byte appended
// - quality value is unsigned 0 to 255 from correlation results
// - quality value valid only for payloads of two octets or more
// - quality recomputed per frame from several symbol correlations
// - status bit 7 reads 0 while pending, 1 when done, cleared by request
// - result available 140 us after request in listening state
`timescale 1ns/1ps
`include "ccl_map.svh"
module ccl_bank #(
   parameter int ASSESS_CYCLES = `CCL_ASSESS_CYCLES
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // register port from spi slave
   input wire ccl_pkg::ccl_reg_req_t i_reg_req,
   input wire logic i_reg_valid,
   output logic [7:0] o_reg_rdata,
   // transceiver state bits shown in status[4:0]
   input wire logic [4:0] i_trx_state,
   // measurement front end, signed dBm
   input wire logic signed [7:0] i_rx_power,
   input wire logic signed [7:0] i_floor,
   input wire logic i_carrier_seen,
   // received symbols
   input wire logic i_rx_active,
   input wire ccl_pkg::ccl_byte_t i_rx_byte,
   input wire logic i_sym_valid,
   input wire logic [7:0] i_sym_corr,
   input wire logic i_frame_last,
   // outputs
   output logic o_assess_done_event,
   output ccl_pkg::ccl_byte_t o_buf_byte,
   output logic o_frame_end_event
);
   ////////////////////////////////////////////////////////////////
   ccl_pkg::ccl_state_t state;
   ccl_pkg::ccl_state_t next_state;
   logic [7:0] control;
   logic [7:0] thresh;
   logic done_flag;
   logic idle_flag;
   logic [15:0] timer;
   logic busy_seen;
   logic [15:0] corr_sum;
   logic [7:0] corr_cnt;
   logic [7:0] pay_len;
   logic ed_busy;
   logic decide_busy;
   logic wr_ctrl;
   logic wr_thr;
   logic rd_req;
   logic start;
   logic measuring;
   logic timer_end;
   logic finish;
   logic corr_take;
   logic short_frame;
   logic signed [9:0] level;
   logic [7:0] lqi;
   logic [7:0] quality;
   logic [7:0] status;
   logic [7:0] rd_mux;
   ccl_pkg::ccl_method_t method;
   ////////////////////////////////////////////////////////////////
   assign wr_ctrl = i_reg_valid && i_reg_req.we && i_reg_req.addr == `CCL_ADDR_CONTROL;
   assign wr_thr = i_reg_valid && i_reg_req.we && i_reg_req.addr == `CCL_ADDR_THRESH;
   assign rd_req = i_reg_valid && !i_reg_req.we;
   assign start = wr_ctrl && i_reg_req.wdata[`CCL_BIT_REQ];
   assign measuring = state == ccl_pkg::CCL_MEASURE;
   assign method = ccl_pkg::ccl_method_t'(control[`CCL_METHOD_HI:`CCL_METHOD_LO]);
   assign level = 10'(i_floor) + 10'({thresh[`CCL_THR_HI:`CCL_THR_LO], 1'b0});
   assign ed_busy = 10'(i_rx_power) > level;
   assign decide_busy = (method == ccl_pkg::CCL_M_OR) ? (ed_busy || i_carrier_seen) :
                        (method == ccl_pkg::CCL_M_ENERGY) ? ed_busy :
                        (method == ccl_pkg::CCL_M_CARRIER) ? i_carrier_seen :
                        (ed_busy && i_carrier_seen);
   assign timer_end = measuring && timer == 16'(ASSESS_CYCLES - 1);
   // a request in the last cycle restarts the window rather than ending it
   assign finish = timer_end && !start;
   // average correlation, counter stops at a byte
   assign lqi = (corr_cnt == 8'h00) ? 8'h00 : 8'(corr_sum / 16'(corr_cnt));
   assign corr_take = i_rx_active && i_sym_valid && corr_cnt != 8'hff;
   // short frames get a zero byte
   assign short_frame = pay_len < `CCL_LQI_MIN_LEN;
   assign quality = short_frame ? 8'h00 : lqi;
   assign status = {done_flag, idle_flag, 1'b0, i_trx_state};
   // unmapped addresses read as zero
   assign rd_mux = (i_reg_req.addr == `CCL_ADDR_STATUS) ? status :
                   (i_reg_req.addr == `CCL_ADDR_CONTROL) ? control :
                   (i_reg_req.addr == `CCL_ADDR_THRESH) ? thresh :
                   8'h00;
   ////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      case (state)
         ccl_pkg::CCL_IDLE: begin
            if (start) begin
               next_state = ccl_pkg::CCL_MEASURE;
            end
         end
         ccl_pkg::CCL_MEASURE: begin
            if (finish) begin
               next_state = ccl_pkg::CCL_IDLE;
            end
         end
         default: next_state = ccl_pkg::CCL_IDLE;
      endcase
   end
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state <= ccl_pkg::CCL_IDLE;
      end else begin
         state <= next_state;
      end
   end
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         control <= `CCL_CTRL_RESET;
         thresh <= `CCL_THRESH_RESET;
      end else begin
         if (wr_ctrl) begin
            // request bit never stored so it reads as zero
            control <= {1'b0, i_reg_req.wdata[`CCL_BIT_REQ - 1:0]};
         end
         if (wr_thr) begin
            thresh <= i_reg_req.wdata;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         timer <= 16'h0000;
         busy_seen <= 1'b0;
      end else if (start) begin
         timer <= 16'h0000;
         busy_seen <= 1'b0;
      end else if (measuring) begin
         timer <= timer + 16'h0001;
         busy_seen <= busy_seen || decide_busy;
      end
   end
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         done_flag <= 1'b0;
         idle_flag <= 1'b0;
         o_assess_done_event <= 1'b0;
      end else begin
         o_assess_done_event <= finish;
         if (start) begin
            done_flag <= 1'b0;
            idle_flag <= 1'b0;
         end else if (timer_end) begin
            done_flag <= 1'b1;
            idle_flag <= !(busy_seen || decide_busy);
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_reg_rdata <= 8'h00;
      end else if (rd_req) begin
         o_reg_rdata <= rd_mux;
      end
   end
   ////////////////////////////////////////////////////////////////
   // payload bytes pass through, quality byte follows the last one
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         corr_sum <= 16'h0000;
         corr_cnt <= 8'h00;
      end else if (i_frame_last) begin
         corr_sum <= 16'h0000;
         corr_cnt <= 8'h00;
      end else if (corr_take) begin
         corr_sum <= corr_sum + 16'(i_sym_corr);
         corr_cnt <= corr_cnt + 8'h01;
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         pay_len <= 8'h00;
      end else if (i_frame_last) begin
         pay_len <= 8'h00;
      end else if (i_rx_byte.valid) begin
         pay_len <= pay_len + 8'h01;
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_buf_byte <= '0;
         o_frame_end_event <= 1'b0;
      end else begin
         o_buf_byte <= i_rx_byte;
         o_frame_end_event <= i_frame_last;
         if (i_frame_last) begin
            o_buf_byte.valid <= 1'b1;
            o_buf_byte.data <= quality;
         end
      end
   end
endmodule // ccl_bank

// [hw/ccl_map.svh]
// register offsets, field positions, reset values and timing for the assessment bank
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH
`define CCL_ADDR_STATUS 6'h01
`define CCL_ADDR_CONTROL 6'h08
`define CCL_ADDR_THRESH 6'h09
`define CCL_BIT_DONE 7
`define CCL_BIT_IDLE 6
`define CCL_BIT_REQ 7
`define CCL_METHOD_HI 6
`define CCL_METHOD_LO 5
`define CCL_THR_HI 4
`define CCL_THR_LO 0
`define CCL_CTRL_RESET 8'h00
`define CCL_THRESH_RESET 8'hc7
`define CCL_ASSESS_TIME_NS 140000
`define CCL_CLK_PERIOD_NS 100
`define CCL_ASSESS_CYCLES (`CCL_ASSESS_TIME_NS / `CCL_CLK_PERIOD_NS)
`define CCL_LQI_MIN_LEN 8'h02
`endif

// [hw/ccl_pkg.sv]
// types shared by the assessment and quality bank
package ccl_pkg;
   typedef enum logic [1:0] {
      CCL_M_OR = 2'b00,
      CCL_M_ENERGY = 2'b01,
      CCL_M_CARRIER = 2'b10,
      CCL_M_AND = 2'b11
   } ccl_method_t;
   typedef enum logic [0:0] {
      CCL_IDLE = 1'b0,
      CCL_MEASURE = 1'b1
   } ccl_state_t;
   typedef struct packed {
      logic we;
      logic [5:0] addr;
      logic [7:0] wdata;
   } ccl_reg_req_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ccl_byte_t;
endpackage
